// *** rtl/usp_defines.svh ***
// offsets, field positions, reset values and timing counts of the bank
`ifndef USP_DEFINES_SVH
`define USP_DEFINES_SVH

// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define USP_OFS_DESIGN_VERSION       16'h9000
`define USP_OFS_DESIGN_STATUS        16'h9008
`define USP_OFS_TX_UTILIZATION_COUNT 16'h900c
`define USP_OFS_RX_UTILIZATION_COUNT 16'h9010
`define USP_OFS_UPSTREAM_WRITE_COUNT 16'h9014

// ----------------------------------------------------------------------
// design_version fields
// ----------------------------------------------------------------------
`define USP_VER_MINOR_LSB   0
`define USP_VER_MAJOR_LSB   4
`define USP_VER_ENGINE_LSB  8
`define USP_VER_FAMILY_LSB  16

// ----------------------------------------------------------------------
// design_status fields
// ----------------------------------------------------------------------
`define USP_STAT_CALIB_BIT      0
`define USP_STAT_SHIM_RST_BIT   1
`define USP_STAT_FIFO_LSB       2
`define USP_STAT_PHY0_BIT       30
`define USP_STAT_PHY1_BIT       31
`define USP_STAT_SHIM_RST_RESET 1'h1

// ----------------------------------------------------------------------
// performance counter fields
// ----------------------------------------------------------------------
`define USP_PERF_SAMPLE_LSB   0
`define USP_PERF_COUNT_LSB    2
`define USP_PERF_COUNT_RESET  30'h0
`define USP_PERF_SAMPLE_RESET 2'h0

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define USP_CLK_PERIOD_NS      10
`define USP_SAMPLE_PERIOD_MS   1000
`define USP_SAMPLE_CYCLES \
  ((`USP_SAMPLE_PERIOD_MS * 1000000) / `USP_CLK_PERIOD_NS)
`define USP_SHIM_CLEAR_CYCLES  4'h9

`endif

// *** rtl/usp_pkg.sv ***
// types shared by the user-space status and performance bank
package usp_pkg;

  // host register port request
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [15:0] addr;
    logic [31:0] wdata;
  } usp_req_s;

  // host register port answer
  typedef struct packed {
    logic        valid;
    logic [31:0] data;
  } usp_rsp_s;

  // status levels from pins outside the clock domain
  typedef struct packed {
    logic [1:0] phy_link;
    logic [3:0] memory_fifo_empty_flags;
    logic       calib_done;
  } usp_pins_s;

  // dword increments per cycle: 0 tx, 1 rx, 2 upstream write
  typedef logic [2:0][3:0] usp_inc_t;

  // the whole state of the bank
  typedef struct packed {
    usp_pins_s        sync1;
    usp_pins_s        sync2;
    logic             shim_rst_n;
    logic [3:0]       shim_cnt;
    logic [31:0]      sec_cnt;
    logic [2:0][29:0] acc;
    logic [2:0][29:0] count;
    logic [2:0][1:0]  sample;
    usp_rsp_s         rsp;
  } usp_state_s;

endpackage

// *** rtl/usp_regs.sv ***
// user-space version, status and performance counter register bank
`timescale 1ns/1ps

`include "usp_defines.svh"

module usp_regs
#(
  parameter int unsigned SECOND_CYCLES = `USP_SAMPLE_CYCLES,
  // identity values below are arbitrary
  parameter logic [3:0]  VER_MINOR     = 4'h2,
  parameter logic [3:0]  VER_MAJOR     = 4'h3,
  parameter logic [7:0]  VER_ENGINE    = 8'h21,
  parameter logic [3:0]  VER_FAMILY    = 4'h5
)
(
  input  wire logic              sys_clk,
  input  wire logic              reset,
  input  wire logic              clk_en,
  input  wire usp_pkg::usp_req_s host_req,
  output      usp_pkg::usp_rsp_s host_rsp,
  input  wire usp_pkg::usp_pins_s status_pins,
  input  wire usp_pkg::usp_inc_t perf_inc,
  output      logic              interconnect_shim_reset_n
);

  import usp_pkg::*;

  // --------------------------------------------------------------------
  // state
  // --------------------------------------------------------------------
  usp_state_s state_reg;
  usp_state_s state_next;

  localparam logic [31:0] SEC_LAST = 32'(SECOND_CYCLES - 1);

  // --------------------------------------------------------------------
  // address decode
  // --------------------------------------------------------------------
  logic hit_version;
  logic hit_status;
  logic hit_tx;
  logic hit_rx;
  logic hit_up;
  logic status_wr;
  logic sec_tick;

  always_comb
  begin
    hit_version = (host_req.addr == `USP_OFS_DESIGN_VERSION);
    hit_status  = (host_req.addr == `USP_OFS_DESIGN_STATUS);
    hit_tx      = (host_req.addr == `USP_OFS_TX_UTILIZATION_COUNT);
    hit_rx      = (host_req.addr == `USP_OFS_RX_UTILIZATION_COUNT);
    hit_up      = (host_req.addr == `USP_OFS_UPSTREAM_WRITE_COUNT);
    status_wr   = host_req.wr && hit_status;
    sec_tick    = (state_reg.sec_cnt == SEC_LAST);
  end

  // --------------------------------------------------------------------
  // register images
  // --------------------------------------------------------------------
  logic [31:0] version_word;
  logic [31:0] status_word;
  logic [2:0][31:0] perf_word;

  always_comb
  begin
    version_word = 32'h0;
    version_word[`USP_VER_MINOR_LSB +: 4]  = VER_MINOR;
    version_word[`USP_VER_MAJOR_LSB +: 4]  = VER_MAJOR;
    version_word[`USP_VER_ENGINE_LSB +: 8] = VER_ENGINE;
    version_word[`USP_VER_FAMILY_LSB +: 4] = VER_FAMILY;
  end

  always_comb
  begin
    status_word = 32'h0;
    status_word[`USP_STAT_CALIB_BIT] =
      state_reg.sync2.calib_done;
    status_word[`USP_STAT_SHIM_RST_BIT] = state_reg.shim_rst_n;
    status_word[`USP_STAT_FIFO_LSB +: 4] =
      state_reg.sync2.memory_fifo_empty_flags;
    status_word[`USP_STAT_PHY0_BIT] =
      state_reg.sync2.phy_link[0];
    status_word[`USP_STAT_PHY1_BIT] =
      state_reg.sync2.phy_link[1];
  end

  always_comb
  begin
    for (int i = 0; i < 3; i++)
    begin
      perf_word[i] = 32'h0;
      perf_word[i][`USP_PERF_SAMPLE_LSB +: 2] =
        state_reg.sample[i];
      perf_word[i][`USP_PERF_COUNT_LSB +: 30] =
        state_reg.count[i];
    end
  end

  // --------------------------------------------------------------------
  // next state
  // --------------------------------------------------------------------
  always_comb
  begin
    state_next = state_reg;

    // status pins pass two flip-flops
    state_next.sync1 = status_pins;
    state_next.sync2 = state_reg.sync1;

    // shim reset bit: write stores, then self clears
    if (status_wr)
    begin
      state_next.shim_rst_n =
        host_req.wdata[`USP_STAT_SHIM_RST_BIT];
      state_next.shim_cnt = `USP_SHIM_CLEAR_CYCLES;
    end
    else if (state_reg.shim_cnt != 4'h0)
    begin
      state_next.shim_cnt = state_reg.shim_cnt - 4'h1;
      if (state_reg.shim_cnt == 4'h1)
      begin
        state_next.shim_rst_n = 1'b0;
      end
    end

    // one-second window
    if (sec_tick)
    begin
      state_next.sec_cnt = 32'h0;
    end
    else
    begin
      state_next.sec_cnt = state_reg.sec_cnt + 32'h1;
    end

    // performance counters, tx rx upstream
    for (int i = 0; i < 3; i++)
    begin
      if (sec_tick)
      begin
        state_next.count[i] =
          state_reg.acc[i] + 30'(perf_inc[i]);
        state_next.acc[i] = 30'h0;
        state_next.sample[i] = state_reg.sample[i] + 2'h1;
      end
      else
      begin
        state_next.acc[i] =
          state_reg.acc[i] + 30'(perf_inc[i]);
      end
    end

    // read answer, one cycle after the request
    state_next.rsp.valid = host_req.rd;
    state_next.rsp.data  = 32'h0;
    if (host_req.rd)
    begin
      case (1'b1)
        hit_version: state_next.rsp.data = version_word;
        hit_status:  state_next.rsp.data = status_word;
        hit_tx:      state_next.rsp.data = perf_word[0];
        hit_rx:      state_next.rsp.data = perf_word[1];
        hit_up:      state_next.rsp.data = perf_word[2];
        default:     state_next.rsp.data = 32'h0;
      endcase
    end
    // other writes touch no state
  end

  // --------------------------------------------------------------------
  // registers
  // --------------------------------------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      state_reg            <= '0;
      state_reg.shim_rst_n <= `USP_STAT_SHIM_RST_RESET;
    end
    else if (clk_en)
    begin
      state_reg <= state_next;
    end
  end

  // --------------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------------
  assign host_rsp                  = state_reg.rsp;
  assign interconnect_shim_reset_n = state_reg.shim_rst_n;

endmodule

// *** test/usp_props.sv ***
// assertion checker for the user-space register bank ports
`timescale 1ns/1ps
module usp_props
#(
  parameter int unsigned SECOND_CYCLES = 20
)
(
  input wire logic               sys_clk,
  input wire logic               reset,
  input wire logic               clk_en,
  input wire usp_pkg::usp_req_s  host_req,
  input wire usp_pkg::usp_rsp_s  host_rsp,
  input wire usp_pkg::usp_pins_s status_pins,
  input wire usp_pkg::usp_inc_t  perf_inc,
  input wire logic               interconnect_shim_reset_n
);
  import usp_pkg::*;
  logic rd;
  logic wst;
  logic quiet;
  assign rd = clk_en && host_req.rd;
  assign wst = clk_en && host_req.wr && host_req.addr == 16'h9008;
  assign quiet = clk_en && !wst;
  // enabled cycles since the last status write, 15 = none or frozen
  logic [3:0] since_wr;
  always_ff @(posedge sys_clk)
  begin
    if (reset || !clk_en)
      since_wr <= 4'hf;
    else if (wst)
      since_wr <= 4'h0;
    else if (since_wr != 4'hf)
      since_wr <= since_wr + 4'h1;
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  // ------------------------------------------------------------------
  // properties
  // ------------------------------------------------------------------
  property p_ans; rd |=> host_rsp.valid; endproperty
  a_ans: assert property (p_ans) else $error("read not answered");
  property p_quiet; clk_en && !host_req.rd |=> !host_rsp.valid; endproperty
  a_quiet: assert property (p_quiet) else $error("stray answer");
  property p_idle; !host_rsp.valid |-> host_rsp.data == 32'h0; endproperty
  a_idle: assert property (p_idle) else $error("idle data set");
  property p_ver; rd && host_req.addr == 16'h9000
    |=> host_rsp.data == 32'h00052132; endproperty
  a_ver: assert property (p_ver) else $error("bad version");
  property p_hole; rd && !(host_req.addr inside {16'h9000, 16'h9008,
    16'h900c, 16'h9010, 16'h9014}) |=> host_rsp.data == 32'h0; endproperty
  a_hole: assert property (p_hole) else $error("hole not zero");
  property p_resv; rd && host_req.addr == 16'h9008
    |=> host_rsp.data[29:6] == 24'h0; endproperty
  a_resv: assert property (p_resv) else $error("reserved set");
  property p_swr; wst
    |=> interconnect_shim_reset_n == $past(host_req.wdata[1]); endproperty
  a_swr: assert property (p_swr) else $error("shim not written");
  property p_shold; wst && host_req.wdata[1] ##1 quiet [*8]
    |=> interconnect_shim_reset_n; endproperty
  a_shold: assert property (p_shold) else $error("shim early");
  property p_sclr; since_wr == 4'h9
    |-> !interconnect_shim_reset_n; endproperty
  a_sclr: assert property (p_sclr) else $error("shim not cleared");
endmodule
bind usp_regs usp_props #(.SECOND_CYCLES(SECOND_CYCLES)) i_usp_props (
  .sys_clk(sys_clk), .reset(reset), .clk_en(clk_en), .host_req(host_req),
  .host_rsp(host_rsp), .status_pins(status_pins), .perf_inc(perf_inc),
  .interconnect_shim_reset_n(interconnect_shim_reset_n));

// *** test/tb_top.sv ***
// self-checking bench for the user-space register bank
`timescale 1ns/1ps
module tb_top;
  import usp_pkg::*;
  localparam int unsigned SEC = 20;
  logic        sys_clk;
  logic        reset;
  logic        clk_en;
  logic        shim_n;
  usp_req_s    host_req;
  usp_rsp_s    host_rsp;
  usp_pins_s   status_pins;
  usp_inc_t    perf_inc;
  logic [31:0] exp_q[$];
  int          miscompares = 0;
  int          checks = 0;
  int          cyc = 0;
  usp_regs #(.SECOND_CYCLES(SEC)) i_usp_regs (
    .sys_clk(sys_clk), .reset(reset), .clk_en(clk_en), .host_req(host_req),
    .host_rsp(host_rsp), .status_pins(status_pins), .perf_inc(perf_inc),
    .interconnect_shim_reset_n(shim_n));
  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) cyc <= reset ? 0 : cyc + (clk_en ? 1 : 0);
  // ------------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------------
  task automatic cmp(string n, logic [31:0] e, logic [31:0] g);
    checks++;
    if (g !== e)
    begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic acc(logic w, logic r, logic [15:0] a, logic [31:0] d,
                     logic [31:0] e);
    host_req = '{w, r, a, d};
    if (r)
      exp_q.push_back(e);
    @(negedge sys_clk);
    host_req.wr = 1'b0;
    host_req.rd = 1'b0;
    @(negedge sys_clk);
  endtask
  function automatic logic [31:0] stexp(logic s);
    return {status_pins.phy_link, 24'h0,
            status_pins.memory_fifo_empty_flags, s, status_pins.calib_done};
  endfunction
  task automatic close_out();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // ------------------------------------------------------------------
  // answer watcher, watchdog and sequence
  // ------------------------------------------------------------------
  always @(negedge sys_clk)
    if (host_rsp.valid === 1'b1)
      cmp("rd_data", exp_q.size() ? exp_q.pop_front() : 'x, host_rsp.data);
  initial
  begin
    repeat (2000) @(posedge sys_clk);
    miscompares++;
    close_out();
  end
  initial
  begin
    host_req = '0;
    status_pins = '0;
    perf_inc = '0;
    clk_en = 1'b1;
    reset = 1'b1;
    void'($urandom(32));
    repeat (20) @(negedge sys_clk);
    reset = 1'b0;
    acc(0, 1, 16'h9008, 0, 32'h2);
    for (int i = 0; i < 3; i++)
      acc(0, 1, 16'h900c + 16'(4 * i), 0, 32'h0);
    acc(1, 0, 16'h9000, '1, 0);
    acc(1, 0, 16'h900c, '1, 0);
    acc(0, 1, 16'h9000, 0, 32'h00052132);
    acc(0, 1, 16'h900c, 0, 32'h0);
    acc(0, 1, 16'h9004, 0, 32'h0);
    acc(0, 1, 16'h9018, 0, 32'h0);
    repeat (4)
    begin
      status_pins = 7'($urandom);
      repeat (4) @(negedge sys_clk);
      acc(0, 1, 16'h9008, 0, stexp(1'b1));
    end
    acc(1, 0, 16'h9008, 32'h0, 0);
    cmp("shim_n", 32'h0, 32'(shim_n));
    acc(1, 0, 16'h9008, '1, 0);
    repeat (7) @(negedge sys_clk);
    cmp("shim_n", 32'h1, 32'(shim_n));
    @(negedge sys_clk);
    cmp("shim_n", 32'h0, 32'(shim_n));
    acc(1, 0, 16'h9008, '1, 0);
    clk_en = 1'b0;
    repeat (12) @(negedge sys_clk);
    cmp("shim_n", 32'h1, 32'(shim_n));
    clk_en = 1'b1;
    repeat (7) @(negedge sys_clk);
    cmp("shim_n", 32'h1, 32'(shim_n));
    @(negedge sys_clk);
    cmp("shim_n", 32'h0, 32'(shim_n));
    acc(0, 1, 16'h9008, 0, stexp(1'b0));
    repeat (2)
    begin
      perf_inc = 12'($urandom);
      repeat (45) @(negedge sys_clk);
      while (cyc % SEC != 10)
        @(negedge sys_clk);
      for (int i = 0; i < 3; i++)
        acc(0, 1, 16'h900c + 16'(4 * i), 0,
            {30'(SEC * perf_inc[i]), 2'(cyc / SEC)});
    end
    repeat (3) @(negedge sys_clk);
    close_out();
  end
endmodule
